// File: common/cfg_pin_pkg.sv
// Shared constants and types for the configuration pin controller.
// Assumes a single system clock domain; all pins but multi_image_en and remote_update_fail are synchronised before use.
package cfg_pin_pkg;

  // ****************************************************************
  // Data path widths and bus width select codes
  // ****************************************************************
  localparam int         DW        = 32;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [2:0] BWS_X1    = 3'h7;
  localparam logic [2:0] BWS_X2    = 3'h6;
  localparam logic [2:0] BWS_X4    = 3'h5;
  localparam logic [2:0] BWS_X8    = 3'h4;
  localparam logic [2:0] BWS_X16   = 3'h3;
  localparam logic [5:0] BW_1      = 6'h01;
  localparam logic [5:0] BW_2      = 6'h02;
  localparam logic [5:0] BW_4      = 6'h04;
  localparam logic [5:0] BW_8      = 6'h08;
  localparam logic [5:0] BW_16     = 6'h10;

  // ****************************************************************
  // Bitstream checks, clock divider and flash read command
  // ****************************************************************
  localparam logic [7:0]  SYNC_SEARCH   = 8'h10;
  localparam logic [31:0] CRC_POLY      = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF;
  localparam logic [3:0]  CCLK_HALF_MAX = 4'h3;
  localparam int          CMD_W         = 10;
  localparam logic [3:0]  CMD_BITS      = 4'hA;

  // ****************************************************************
  // Test access port
  // ****************************************************************
  localparam int           IR_W       = 4;
  localparam logic [3:0]   IR_IDCODE  = 4'h1;
  localparam logic [3:0]   IR_CAPTURE = 4'h1;

  typedef struct packed {
    logic       creset_n;
    logic       cclk;
    logic       csi;
    logic       ss_n;
    logic       test_n;
    logic       tck;
    logic       tms;
    logic       tdi;
    logic       cc;
    logic [2:0] bws;
    logic [1:0] img;
  } ctl_t;

  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SHF_DR, T_EX1_DR, T_PAU_DR, T_EX2_DR,
    T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SHF_IR, T_EX1_IR, T_PAU_IR, T_EX2_IR, T_UPD_IR
  } tap_state_t;

  typedef enum logic [3:0] {
    ST_HOLD, ST_SYNC, ST_ID, ST_LEN, ST_DATA, ST_CRC, ST_DONE, ST_USER, ST_ERR
  } cfg_state_t;

endpackage

// File: common/tap_if.sv
// Carrier between the pin controller and its test access port.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface tap_if;
  logic rise;
  logic fall;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;

  modport ctl (output rise, fall, tms, tdi, input tdo, tdo_oe_n);
  modport tap (input rise, fall, tms, tdi, output tdo, tdo_oe_n);
endinterface

// File: verilog/sync2.sv
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit values are not kept coherent.
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second; both reset to the pulled-up idle level.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: verilog/tap_ctrl.sv
// Boundary-scan test access port with instruction, bypass and identity paths.
// Assumes test clock edges arrive as one-cycle strobes on the system clock.
`timescale 1ns/1ns
module tap_ctrl #(
  parameter logic [31:0] IDCODE = 32'h10000001 // Arbitrary identity value.
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  tap_if.tap        tp
);
  import cfg_pin_pkg::*;

  tap_state_t      st_r;
  tap_state_t      st_nxt;
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] irs_r;
  logic [31:0]     dr_r;
  logic            tdo_r;
  logic            oe_n_r;
  logic            sel_id;

  assign sel_id      = ir_r == IR_IDCODE;
  assign tp.tdo      = tdo_r;
  assign tp.tdo_oe_n = oe_n_r;

  // Standard sixteen-state walk steered by the mode-select level.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      T_RESET:  st_nxt = tp.tms ? T_RESET  : T_IDLE;
      T_IDLE:   st_nxt = tp.tms ? T_SEL_DR : T_IDLE;
      T_SEL_DR: st_nxt = tp.tms ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: st_nxt = tp.tms ? T_EX1_DR : T_SHF_DR;
      T_SHF_DR: st_nxt = tp.tms ? T_EX1_DR : T_SHF_DR;
      T_EX1_DR: st_nxt = tp.tms ? T_UPD_DR : T_PAU_DR;
      T_PAU_DR: st_nxt = tp.tms ? T_EX2_DR : T_PAU_DR;
      T_EX2_DR: st_nxt = tp.tms ? T_UPD_DR : T_SHF_DR;
      T_UPD_DR: st_nxt = tp.tms ? T_SEL_DR : T_IDLE;
      T_SEL_IR: st_nxt = tp.tms ? T_RESET  : T_CAP_IR;
      T_CAP_IR: st_nxt = tp.tms ? T_EX1_IR : T_SHF_IR;
      T_SHF_IR: st_nxt = tp.tms ? T_EX1_IR : T_SHF_IR;
      T_EX1_IR: st_nxt = tp.tms ? T_UPD_IR : T_PAU_IR;
      T_PAU_IR: st_nxt = tp.tms ? T_EX2_IR : T_PAU_IR;
      T_EX2_IR: st_nxt = tp.tms ? T_UPD_IR : T_SHF_IR;
      T_UPD_IR: st_nxt = tp.tms ? T_SEL_DR : T_IDLE;
      default:  st_nxt = T_RESET;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r  <= T_RESET;
      ir_r  <= IR_IDCODE;
      irs_r <= '0;
      dr_r  <= '0;
    end else if (tp.rise) begin
      st_r <= st_nxt;
      case (st_r)
        T_RESET:  ir_r  <= IR_IDCODE;
        T_CAP_IR: irs_r <= IR_CAPTURE;
        T_SHF_IR: irs_r <= {tp.tdi, irs_r[IR_W-1:1]};
        T_UPD_IR: ir_r  <= irs_r;
        T_CAP_DR: dr_r  <= sel_id ? IDCODE : 32'h00000000;
        T_SHF_DR: dr_r  <= sel_id ? {tp.tdi, dr_r[31:1]} : {31'h00000000, tp.tdi};
        default:  ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tdo_r  <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (tp.fall) begin
      oe_n_r <= !(st_r == T_SHF_DR || st_r == T_SHF_IR);
      tdo_r  <= (st_r == T_SHF_IR) ? irs_r[0] : dr_r[0];
    end
  end
endmodule

// File: verilog/config_pin_controller.sv
// Configuration pin logic: reset, mode straps, serial or parallel loader,
// status pins, cascade select and the test access port.
// Assumes pads provide pull-ups and resolve open-drain lines from the enables.
// Function
// - Release done line only after configuration.
// - Stay out of user mode while done low.
// - Test inputs sampled on test clock rise.
// - Test output changes after test clock fall.
// - Undriven test inputs read as one.
// - Test data passes selected register, delayed.
// - Test output released when not shifting.
// - Image select picks image when enabled.
// - Config clock input passive, output active.
// - Data pin roles swap between modes.
// - Accept data only while chip select high.
// - Drive chip select out for next device.
// - Error output low on bitstream faults.
// - Slave select at reset release picks mode.
// - Slave select drives flash in active mode.
// - Release dual-purpose pins in user mode.
// - Dedicated pins never become general I/O.
`timescale 1ns/1ns
module config_pin_controller #(
  parameter logic [31:0] SYNC_WORD = 32'hA5C35A3C,
  parameter logic [31:0] DEVICE_ID = 32'h00C0FFEE, // Arbitrary identity value.
  parameter logic [7:0]  READ_CMD  = 8'h03
) (
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic                       creset_n,
  input  wire logic                       cfg_clock_i,
  output logic                            cfg_clock_o,
  output logic                            cfg_clock_oe_n,
  input  wire logic [cfg_pin_pkg::DW-1:0] cfg_data_i,
  output logic      [cfg_pin_pkg::DW-1:0] cfg_data_o,
  output logic      [cfg_pin_pkg::DW-1:0] cfg_data_oe_n,
  input  wire logic                       chip_select_in,
  output logic                            cfg_chip_select_out,
  input  wire logic                       ss_n_i,
  output logic                            ss_n_o,
  output logic                            ss_n_oe_n,
  input  wire logic [2:0]                 bus_width_select,
  input  wire logic [1:0]                 image_select,
  input  wire logic                       multi_image_en,
  input  wire logic                       remote_update_fail,
  input  wire logic                       test_n,
  output logic                            test_mode,
  input  wire logic                       tck,
  input  wire logic                       tms,
  input  wire logic                       tdi,
  output logic                            tdo,
  output logic                            tdo_oe_n,
  input  wire logic                       config_complete_i,
  output logic                            config_complete_o,
  output logic                            config_complete_oe_n,
  output logic                            cfg_error_n,
  output logic                            user_mode,
  output logic                            dual_io_release,
  output logic                            cfg_mode_active,
  output logic      [1:0]                 load_image,
  output logic      [cfg_pin_pkg::DW-1:0] cfg_word,
  output logic                            cfg_word_vld
);
  import cfg_pin_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  ctl_t                    ctl_raw;
  ctl_t                    ctl_s;
  logic [$bits(ctl_t)-1:0] ctl_bits;
  logic [DW-1:0]           din_s;

  assign ctl_raw = {creset_n, cfg_clock_i, chip_select_in, ss_n_i, test_n, tck, tms, tdi,
                    config_complete_i, bus_width_select, image_select};
  assign ctl_s   = ctl_bits;

  sync2 #(.W($bits(ctl_t))) u_sync_ctl (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (ctl_raw),
    .q       (ctl_bits)
  );

  sync2 #(.W(DW)) u_sync_data (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (cfg_data_i),
    .q       (din_s)
  );

  // ****************************************************************
  // State and edge detection
  // ****************************************************************
  cfg_state_t       st_r;
  cfg_state_t       st_nxt;
  logic             rst_d_r;
  logic             cclk_d_r;
  logic             tck_d_r;
  logic             mode_act_r;
  logic [1:0]       img_r;
  logic [5:0]       cnt_r;
  logic [DW-1:0]    word_r;
  logic [7:0]       srch_r;
  logic [31:0]      len_r;
  logic [31:0]      crc_r;
  logic [31:0]      crc_nxt;
  logic [3:0]       div_cnt_r;
  logic             cclk_o_r;
  logic [CMD_W-1:0] cmd_r;
  logic [3:0]       cmd_cnt_r;
  logic             data0_r;
  logic             data1_r;
  logic             rst_rise;
  logic             loading;
  logic             drive_act;
  logic             div_tick;
  logic             div_rise;
  logic             div_fall;
  logic             pas_rise;
  logic             take;
  logic             word_done;
  logic [5:0]       bw;
  logic [5:0]       cnt_sum;
  logic [DW-1:0]    din_mask;
  logic [DW-1:0]    din_eff;
  logic [DW-1:0]    word_nxt;
  logic [1:0]       img_pick;
  logic             reached_done;
  tap_if            ti ();

  assign rst_rise  = ctl_s.creset_n & ~rst_d_r;
  assign loading   = st_r inside {ST_SYNC, ST_ID, ST_LEN, ST_DATA, ST_CRC};
  assign drive_act = mode_act_r & loading;
  assign div_tick  = div_cnt_r == CCLK_HALF_MAX;
  assign div_rise  = drive_act & div_tick & ~cclk_o_r;
  assign div_fall  = drive_act & div_tick & cclk_o_r;
  assign pas_rise  = ~mode_act_r & ctl_s.cclk & ~cclk_d_r;
  assign take      = (div_rise | pas_rise) & ctl_s.csi & loading & (cmd_cnt_r == 4'h0);

  assign bw = (ctl_s.bws == BWS_X1)  ? BW_1  :
              (ctl_s.bws == BWS_X2)  ? BW_2  :
              (ctl_s.bws == BWS_X4)  ? BW_4  :
              (ctl_s.bws == BWS_X8)  ? BW_8  :
              (ctl_s.bws == BWS_X16) ? BW_16 : WORD_BITS;

  assign din_mask  = (bw == WORD_BITS) ? {DW{1'b1}} : ((32'h00000001 << bw) - 32'h00000001);
  assign din_eff   = (mode_act_r && bw == BW_1) ? {{(DW-1){1'b0}}, din_s[1]} : (din_s & din_mask);
  assign word_nxt  = (word_r << bw) | din_eff;
  assign cnt_sum   = cnt_r + bw;
  assign word_done = take & (cnt_sum == WORD_BITS);
  assign img_pick  = multi_image_en ? ctl_s.img : 2'h0;
  assign reached_done = st_nxt == ST_DONE || st_nxt == ST_USER;

  // Running CRC over payload words, MSB first; one word per update.
  always_comb begin
    crc_nxt = crc_r;
    for (int i = DW - 1; i >= 0; i--) begin
      crc_nxt = {crc_nxt[30:0], 1'b0} ^ ((crc_nxt[31] ^ word_nxt[i]) ? CRC_POLY : 32'h00000000);
    end
  end

  // ****************************************************************
  // Configuration sequence
  // ****************************************************************
  // Word-aligned hunt keeps the logic small; the sync word must start on a word boundary.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_HOLD: begin
        if (rst_rise) begin
          st_nxt = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (word_done && word_nxt == SYNC_WORD) begin
          st_nxt = ST_ID;
        end else if (word_done && srch_r == SYNC_SEARCH - 8'h01) begin
          st_nxt = ST_ERR;
        end
      end
      ST_ID: begin
        if (word_done) begin
          st_nxt = (word_nxt == DEVICE_ID) ? ST_LEN : ST_ERR;
        end
      end
      ST_LEN: begin
        if (word_done) begin
          st_nxt = (word_nxt == 32'h00000000) ? ST_CRC : ST_DATA;
        end
      end
      ST_DATA: begin
        if (word_done && len_r == 32'h00000001) begin
          st_nxt = ST_CRC;
        end
      end
      ST_CRC: begin
        if (word_done) begin
          st_nxt = (word_nxt == crc_r) ? ST_DONE : ST_ERR;
        end
      end
      ST_DONE: begin
        if (ctl_s.cc) begin
          st_nxt = ST_USER;
        end
      end
      default: ;
    endcase
    if (remote_update_fail && st_r != ST_HOLD && st_r != ST_USER) begin
      st_nxt = ST_ERR;
    end
    if (!ctl_s.creset_n) begin
      st_nxt = ST_HOLD;
    end
  end

  // Sequence state, edge history and mode capture.
  // mode strap at release.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r       <= ST_HOLD;
      rst_d_r    <= 1'b1; // Pins idle high, so no false edge follows reset.
      cclk_d_r   <= 1'b1;
      tck_d_r    <= 1'b1;
      mode_act_r <= 1'b0;
      img_r      <= 2'h0;
    end else begin
      st_r     <= st_nxt;
      rst_d_r  <= ctl_s.creset_n;
      cclk_d_r <= ctl_s.cclk;
      tck_d_r  <= ctl_s.tck;
      if (rst_rise) begin
        mode_act_r <= ctl_s.ss_n;
        img_r      <= img_pick;
      end
    end
  end

  // Word assembly, search count, length and checksum.
  always_ff @(posedge sys_clk) begin
    if (srst || !loading) begin
      cnt_r  <= 6'h00;
      word_r <= '0;
      srch_r <= 8'h00;
      len_r  <= 32'h00000000;
      crc_r  <= CRC_INIT;
    end else if (take) begin
      cnt_r  <= word_done ? 6'h00 : cnt_sum;
      word_r <= word_nxt;
      if (word_done && st_r == ST_SYNC) begin
        srch_r <= srch_r + 8'h01;
      end
      if (word_done && st_r == ST_LEN) begin
        len_r <= word_nxt;
      end
      if (word_done && st_r == ST_DATA) begin
        len_r <= len_r - 32'h00000001;
        crc_r <= crc_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || !drive_act) begin
      div_cnt_r <= 4'h0;
      cclk_o_r  <= 1'b1;
    end else begin
      div_cnt_r <= div_tick ? 4'h0 : div_cnt_r + 4'h1;
      if (div_tick) begin
        cclk_o_r <= ~cclk_o_r;
      end
    end
  end

  // Flash read command with the image number, shifted on falling clock edges.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_r     <= '0;
      cmd_cnt_r <= 4'h0;
      data0_r   <= 1'b0;
      data1_r   <= 1'b0;
    end else if (rst_rise) begin
      cmd_r     <= {READ_CMD, img_pick};
      cmd_cnt_r <= ctl_s.ss_n ? CMD_BITS : 4'h0;
    end else begin
      if (div_fall && cmd_cnt_r != 4'h0) begin
        data0_r   <= cmd_r[CMD_W-1];
        cmd_r     <= {cmd_r[CMD_W-2:0], 1'b0};
        cmd_cnt_r <= cmd_cnt_r - 4'h1;
      end
      if (pas_rise) begin
        data1_r <= din_s[0];
      end
    end
  end

  // ****************************************************************
  // Pin and status outputs
  // ****************************************************************
  // Outputs are registered so the pads see no decode glitches.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_clock_o          <= 1'b1;
      cfg_clock_oe_n       <= 1'b1;
      cfg_data_o           <= '0;
      cfg_data_oe_n        <= '1;
      ss_n_o               <= 1'b1;
      ss_n_oe_n            <= 1'b1;
      cfg_chip_select_out  <= 1'b0;
      config_complete_oe_n <= 1'b0;
      cfg_error_n          <= 1'b1;
      user_mode            <= 1'b0;
      dual_io_release      <= 1'b0;
      test_mode            <= 1'b0;
      cfg_word             <= '0;
      cfg_word_vld         <= 1'b0;
    end else begin
      cfg_clock_o          <= cclk_o_r;
      cfg_clock_oe_n       <= ~drive_act;
      cfg_data_o           <= {{(DW-2){1'b0}}, data1_r, data0_r};
      cfg_data_oe_n        <= {{(DW-2){1'b1}}, ~(loading & ~mode_act_r), ~drive_act};
      ss_n_o               <= ~drive_act;
      ss_n_oe_n            <= ~drive_act;
      cfg_chip_select_out  <= reached_done;
      config_complete_oe_n <= reached_done;
      cfg_error_n          <= st_nxt != ST_ERR;
      user_mode            <= st_nxt == ST_USER;
      dual_io_release      <= st_nxt == ST_USER;
      test_mode            <= ~ctl_s.test_n;
      cfg_word             <= word_nxt;
      cfg_word_vld         <= word_done && st_r == ST_DATA;
    end
  end

  assign config_complete_o = 1'b0;
  assign cfg_mode_active   = mode_act_r;
  assign load_image        = img_r;

  // ****************************************************************
  // Test access port
  // ****************************************************************
  // edges from sampled clock.
  assign ti.rise  = ctl_s.tck & ~tck_d_r;
  assign ti.fall  = ~ctl_s.tck & tck_d_r;
  assign ti.tms   = ctl_s.tms;
  assign ti.tdi   = ctl_s.tdi;
  assign tdo      = ti.tdo;
  assign tdo_oe_n = ti.tdo_oe_n;

  tap_ctrl u_tap (
    .sys_clk (sys_clk),
    .srst    (srst),
    .tp      (ti.tap)
  );
endmodule

// File: verif/config_pin_controller_assertions.sv
// Concurrent checks on the top ports of the configuration pin controller.
// Assumes one sys_clk domain with srst as its synchronous reset.
`timescale 1ns/1ns
module config_pin_controller_assertions (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic creset_n,
  input wire logic chip_select_in,
  input wire logic tck,
  input wire logic config_complete_i,
  input wire logic config_complete_o,
  input wire logic config_complete_oe_n,
  input wire logic cfg_error_n,
  input wire logic user_mode,
  input wire logic dual_io_release,
  input wire logic cfg_chip_select_out,
  input wire logic cfg_mode_active,
  input wire logic cfg_clock_oe_n,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic cfg_word_vld
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ****************************************************************
  // Status pins and modes
  // ****************************************************************
  a_done_open: assert property (config_complete_o == 1'h0)
    else $error("done pin driven high");
  a_user_held: assert property (!config_complete_i [*4] ##1 !user_mode |=> !user_mode)
    else $error("user mode entered with done line low");
  a_err_holds: assert property (!cfg_error_n && creset_n && $past(creset_n)
    && $past(creset_n, 2) && $past(creset_n, 3) |=> !cfg_error_n)
    else $error("error cleared without reset pulse");
  a_err_no_user: assert property (!cfg_error_n |-> !user_mode && !cfg_chip_select_out)
    else $error("error with user mode or cascade select");
  a_cso_done: assert property (cfg_chip_select_out == config_complete_oe_n)
    else $error("cascade select out of step with done");
  a_passive_quiet: assert property (!cfg_mode_active |-> cfg_clock_oe_n)
    else $error("clock driven in passive mode");
  a_user_pins: assert property (user_mode |-> dual_io_release && cfg_clock_oe_n)
    else $error("pins not released in user mode");
  a_csi_off: assert property (!chip_select_in [*4] |=> !cfg_word_vld)
    else $error("word taken while unselected");
  // ****************************************************************
  // Test access port timing
  // ****************************************************************
  a_tdo_hold: assert property (tck [*6] |-> $stable(tdo) && $stable(tdo_oe_n))
    else $error("test output moved with test clock high");
  a_oe_on_low: assert property ($fell(tdo_oe_n) |-> !tck)
    else $error("test output enabled outside a low phase");
endmodule

bind config_pin_controller config_pin_controller_assertions u_chk (
  .sys_clk, .srst, .creset_n, .chip_select_in, .tck, .config_complete_i, .config_complete_o,
  .config_complete_oe_n, .cfg_error_n, .user_mode, .dual_io_release, .cfg_chip_select_out,
  .cfg_mode_active, .cfg_clock_oe_n, .tdo, .tdo_oe_n, .cfg_word_vld
);

// File: verif/cfg_host.sv
// Host that clocks a bitstream into the device in passive single-bit mode.
// Assumes the device samples clock and data on its own unrelated system clock.
`timescale 1ns/1ns
module cfg_host (
  output logic clk_pin,
  output logic data_pin
);
  // The clock stands still high between frames, as the pin's pull-up leaves it.
  initial begin
    clk_pin = 1'h1;
    data_pin = 1'h0;
  end
  task automatic send(input logic [31:0] w, input int slow);
    #3;
    for (int i = 31; i >= 0; i--) begin
      clk_pin = 1'h0;
      data_pin = w[i];
      #40;
      clk_pin = 1'h1;
      #40;
    end
    // A released line shows the inverse, so a stale bit never reads as good.
    data_pin = ~w[0];
    #(slow);
  endtask
endmodule

// File: verif/tb_config_pin_controller.sv
// Self-checking bench: passive loads, a fault, user mode and the test port.
// Assumes cfg_host clocks the bitstream; the bench pulls the done line up.
`timescale 1ns/1ns
module tb_config_pin_controller;
  import cfg_pin_pkg::*;
  localparam logic [31:0] SYNC = 32'hA5C35A3C;
  localparam logic [31:0] DEV  = 32'h00C0FFEE; // Arbitrary, equal to the design default.
  localparam logic [31:0] IDC  = 32'h10000001; // Arbitrary, equal to the tap default.
  logic        sys_clk, srst, creset_n, csi, hold_low, ruf, tn, tck, tms, tdi, b, hclk, hdat;
  logic        cfg_clock_oe_n, cfg_chip_select_out, test_mode, tdo, tdo_oe_n, cfg_word_vld;
  logic        config_complete_o, config_complete_oe_n, cfg_error_n, user_mode;
  logic        dual_io_release, cfg_mode_active, ssn, ssoe;
  logic [31:0] cfg_data_oe_n, cfg_word, exp_q[$];
  logic        bq[$];
  int          mismatches, n_compared;
  // Open-drain done line with pull-up; the bench may hold it low as a peer.
  wire         done_line = config_complete_oe_n ? ~hold_low : config_complete_o;

  cfg_host host (.clk_pin(hclk), .data_pin(hdat));
  config_pin_controller dut (
    .sys_clk, .srst, .creset_n, .cfg_clock_i(hclk), .cfg_clock_o(), .cfg_clock_oe_n,
    .cfg_data_i({31'h0, hdat}), .cfg_data_o(), .cfg_data_oe_n, .chip_select_in(csi),
    .cfg_chip_select_out, .ss_n_i(ssn), .ss_n_o(), .ss_n_oe_n(ssoe), .bus_width_select(BWS_X1),
    .image_select(2'h0), .multi_image_en(1'h0), .remote_update_fail(ruf), .test_n(tn),
    .test_mode, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .config_complete_i(done_line),
    .config_complete_o, .config_complete_oe_n, .cfg_error_n, .user_mode, .dual_io_release,
    .cfg_mode_active, .load_image(), .cfg_word, .cfg_word_vld
  );

  // ****************************************************************
  // Clock, comparison and model helpers
  // ****************************************************************
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Bitwise CRC, most significant bit first, kept apart from the design's code.
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
      c = {c[30:0], 1'h0} ^ ((c[31] ^ w[i]) ? CRC_POLY : 32'h0);
    return c;
  endfunction
  // Every payload word must be the next one the model queued.
  always @(negedge sys_clk)
    if (cfg_word_vld === 1'h1)
      chk("word", cfg_word, exp_q.size() ? exp_q.pop_front() : 32'hX);
  // reset pulse, then junk, sync, identity, length, data and CRC words
  task automatic load(input int n, input logic [31:0] flip);
    logic [31:0] c;
    logic [31:0] w;
    c = CRC_INIT;
    @(posedge sys_clk);
    creset_n <= 1'h0;
    repeat (20) @(posedge sys_clk);
    chk("error_n", cfg_error_n, 1);
    creset_n <= 1'h1;
    repeat (6) @(posedge sys_clk);
    host.send($urandom, 0);
    host.send(SYNC, 0);
    host.send(DEV, 400);
    host.send(n, 0);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      if (csi) exp_q.push_back(w);
      c = crc(c, w);
      host.send(w, 0);
    end
    host.send(c ^ flip, 0);
    repeat (10) @(negedge sys_clk);
  endtask
  // One test clock period; slow phases keep the synchronised edges clear.
  task automatic tap_step(input logic m, input logic d);
    @(posedge sys_clk);
    tms <= m;
    tdi <= d;
    repeat (6) @(posedge sys_clk);
    tck <= 1'h1;
    repeat (6) @(posedge sys_clk);
    tck <= 1'h0;
    repeat (6) @(negedge sys_clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    srst = 1'h1;
    creset_n = 1'h1;
    csi = 1'h0;
    ssn = 1'h0;
    hold_low = 1'h0;
    ruf = 1'h0;
    tn = 1'h1;
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'hB4E8));
    repeat (20) @(posedge sys_clk);
    srst <= 1'h0;
    @(negedge sys_clk);
    chk("done_oe_n", config_complete_oe_n, 0);
    chk("tdo_oe_n", tdo_oe_n, 1);
    chk("test_mode", test_mode, 0);
    // An unselected device ignores a whole good stream.
    load(0, 0);
    chk("done_oe_n", config_complete_oe_n, 0);
    @(posedge sys_clk);
    csi <= 1'h1;
    load(1, 32'h1);
    chk("error_n", cfg_error_n, 0);
    repeat (50) @(negedge sys_clk);
    chk("error_n", cfg_error_n, 0);
    @(posedge sys_clk);
    hold_low <= 1'h1;
    load(2, 0);
    chk("done_oe_n", config_complete_oe_n, 1);
    chk("cso", cfg_chip_select_out, 1);
    chk("mode", cfg_mode_active, 0);
    repeat (30) @(negedge sys_clk);
    chk("user_mode", user_mode, 0);
    @(posedge sys_clk);
    hold_low <= 1'h0;
    for (int i = 0; i < 20 && user_mode !== 1'h1; i++) @(negedge sys_clk);
    chk("user_mode", user_mode, 1);
    if (mismatches > 0) wrap_up();
    chk("dual_io", dual_io_release, 1);
    chk("data_oe_n", cfg_data_oe_n, 32'hFFFFFFFF);
    // A late update failure must not disturb a device already in user mode.
    @(posedge sys_clk);
    ruf <= 1'h1;
    repeat (10) @(negedge sys_clk);
    chk("error_n", cfg_error_n, 1);
    chk("queue", exp_q.size(), 0);
    // Walk to shift-DR, read the identity, then see a bench bit 32 shifts later.
    for (int i = 0; i < 32; i++) bq.push_back(IDC[i]);
    tap_step(0, 1);
    tap_step(1, 1);
    tap_step(0, 1);
    tap_step(0, 1);
    chk("tdo_oe_n", tdo_oe_n, 0);
    for (int k = 0; k < 33; k++) begin
      chk("tdo", tdo, bq.pop_front());
      b = 1'($urandom);
      bq.push_back(b);
      tap_step(k == 32, b);
    end
    chk("tdo_oe_n", tdo_oe_n, 1);
    // Strap high: the device drives its own clock and flash select.
    @(posedge sys_clk);
    ruf <= 1'h0;
    ssn <= 1'h1;
    creset_n <= 1'h0;
    repeat (20) @(posedge sys_clk);
    creset_n <= 1'h1;
    repeat (20) @(negedge sys_clk);
    chk("mode", cfg_mode_active, 1);
    chk("cclk_oe_n", cfg_clock_oe_n, 0);
    chk("ss_oe_n", ssoe, 0);
    wrap_up();
  end
endmodule
